// ===== hdl/mirl_map.vh
// Register offsets, field positions and reset values of the interrupt request logic.
`ifndef MIRL_MAP_VH
`define MIRL_MAP_VH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define MIRL_OFF_TIMER_CTRL  8'h00
`define MIRL_OFF_CNT2_CTRL   8'h04
`define MIRL_OFF_EN_PRI      8'h08
`define MIRL_OFF_EN_SEC      8'h0c
`define MIRL_OFF_PRIO_PRI    8'h10
`define MIRL_OFF_PRIO_SEC    8'h14
`define MIRL_OFF_CORE_STAT   8'h18
`define MIRL_OFF_EVT_STAT    8'h1c
`define MIRL_OFF_EVT_CLR     8'h20
`define MIRL_OFF_EVT_EN      8'h24
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MIRL_TC_EDGE0        0
`define MIRL_TC_FLAG0        1
`define MIRL_TC_EDGE1        2
`define MIRL_TC_FLAG1        3
`define MIRL_TC_OVF0         5
`define MIRL_TC_OVF1         7
`define MIRL_C2_OVF          7
`define MIRL_C2_CAP          6
`define MIRL_C2_EXEN         3
`define MIRL_EP_GATE         7
`define MIRL_EP_T2           5
`define MIRL_EP_S1           4
`define MIRL_EP_T1           3
`define MIRL_EP_X1           2
`define MIRL_EP_T0           1
`define MIRL_EP_X0           0
`define MIRL_ES_DDC          7
`define MIRL_ES_S2           4
`define MIRL_ES_I2C          1
`define MIRL_ES_USB          0
`define MIRL_EVT_TAKEN       0
`define MIRL_EVT_DONE        1
`define MIRL_EVT_PREEMPT     2
// ----------------------------------------------------------------------------
// Sources in polling order, widths and reset values
// ----------------------------------------------------------------------------
`define MIRL_SRC_X0          4'h0
`define MIRL_SRC_T0          4'h2
`define MIRL_SRC_X1          4'h4
`define MIRL_SRC_T1          4'h6
`define MIRL_NUM_SRC         10
`define MIRL_NUM_PIN         3
`define MIRL_NUM_EVT         3
`define MIRL_RST8            8'h00
`define MIRL_RST_EVT         3'h0
`define MIRL_RST_VEC         4'h0
`define MIRL_PIN_IDLE        3'h7
`define MIRL_T0_SPLIT        2'h3
`endif

// ===== hdl/mirl_sync3.v
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none
`include "mirl_map.vh"
module mirl_sync3 (
   input  wire                      clk_sys,
   input  wire                      rstn,
   input  wire [`MIRL_NUM_PIN-1:0]  pin_in,
   output reg  [`MIRL_NUM_PIN-1:0]  pin_lvl
);
   reg [`MIRL_NUM_PIN-1:0] s1_reg;
   reg [`MIRL_NUM_PIN-1:0] s2_reg;
   reg [`MIRL_NUM_PIN-1:0] s3_reg;
   integer i;

   // A level change is accepted only once stages two and three agree.
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s1_reg  <= `MIRL_PIN_IDLE;
         s2_reg  <= `MIRL_PIN_IDLE;
         s3_reg  <= `MIRL_PIN_IDLE;
         pin_lvl <= `MIRL_PIN_IDLE;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (i = 0; i < `MIRL_NUM_PIN; i = i + 1) begin
            if (s2_reg[i] == s3_reg[i]) begin
               pin_lvl[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== hdl/mirl_arb.v
// Two-level priority arbiter with fixed polling order inside each level.
`timescale 1ns/100ps
`default_nettype none
`include "mirl_map.vh"
module mirl_arb (
   input  wire [`MIRL_NUM_SRC-1:0] req,
   input  wire [`MIRL_NUM_SRC-1:0] prio,
   input  wire                     lo_busy,
   input  wire                     hi_busy,
   output reg                      win_valid,
   output reg  [3:0]               win_idx,
   output reg                      win_prio
);
   reg       hv;
   reg       lv;
   reg [3:0] hidx;
   reg [3:0] lidx;
   integer   i;

   // Scanning downward leaves the lowest index, the first in polling order.
   always @* begin
      hv   = 1'b0;
      lv   = 1'b0;
      hidx = `MIRL_RST_VEC;
      lidx = `MIRL_RST_VEC;
      for (i = `MIRL_NUM_SRC - 1; i >= 0; i = i - 1) begin
         if (req[i] && prio[i]) begin
            hv   = 1'b1;
            hidx = i[3:0];
         end
         if (req[i] && !prio[i]) begin
            lv   = 1'b1;
            lidx = i[3:0];
         end
      end
      win_valid = 1'b0;
      win_idx   = lidx;
      win_prio  = 1'b0;
      if (!hi_busy) begin
         if (hv) begin
            win_valid = 1'b1;
            win_idx   = hidx;
            win_prio  = 1'b1;
         end else if (lv && !lo_busy) begin
            win_valid = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== hdl/mirl_top.v
// Interrupt request logic: flags, enables, priorities, core handshake and APB registers.
//
// Overview of operation
// - Ten sources; external input one also carries converter-done.
// - External input zero is level or edge sensed per edge-select bit.
// - Edge-captured external flag clears when the core vectors to it.
// - Level-mode external flag follows the input, never auto-cleared.
// - Timer 0 and 1 overflow set their flags, except timer 0 split mode.
// - Timer 0 and 1 flags clear when their interrupt is serviced.
// - Timer 2 overflow flag requests and clears only by software write.
// - Timer 2 capture flag sets from its pin when external enable allows.
// - One priority bit per source; high preempts low, nothing preempts high.
// - Equal priority ties resolve by fixed polling order, index zero first.
// - Per-source enables; cleared global gate blocks every acknowledge.
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "mirl_map.vh"
module mirl_top (
   input  wire        clk_sys,
   input  wire        rstn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        external_request_zero_n,
   input  wire        external_request_one_n,
   input  wire        counter_two_external_pin,
   input  wire        adc_done,
   input  wire        t0_overflow,
   input  wire [1:0]  t0_mode,
   input  wire        t1_overflow,
   input  wire        t2_overflow,
   input  wire        usart2_req,
   input  wire        i2c_req,
   input  wire        ddc_req,
   input  wire        usb_req,
   input  wire        usart1_req,
   input  wire        core_ack,
   input  wire        core_return,
   output reg         core_request,
   output reg  [3:0]  core_vector,
   output reg         irq
);
   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   reg [1:0]                edge_select_reg;
   reg [1:0]                ext_flag_reg;
   reg [1:0]                ext_act_prev_reg;
   reg                      counter_zero_overflow_flag_reg;
   reg                      counter_one_overflow_flag_reg;
   reg                      counter_two_overflow_flag_reg;
   reg                      counter_two_capture_flag_reg;
   reg                      counter_two_external_enable_reg;
   reg [7:0]                enable_select_primary_reg;
   reg [7:0]                enable_select_secondary_reg;
   reg [7:0]                priority_select_primary_reg;
   reg [7:0]                priority_select_secondary_reg;
   reg                      core_prio_reg;
   reg                      lo_busy_reg;
   reg                      hi_busy_reg;
   reg                      pin_prev_reg;
   reg [`MIRL_NUM_EVT-1:0]  evt_stat_reg;
   reg [`MIRL_NUM_EVT-1:0]  evt_en_reg;
   reg [`MIRL_NUM_EVT-1:0]  evt_stat_next;
   reg [31:0]               rd_next;
   reg                      hit;

   wire [`MIRL_NUM_PIN-1:0] pin_lvl;
   wire [1:0]               ext_act;
   wire                     cap_fall;
   wire                     taken;
   wire [`MIRL_NUM_SRC-1:0] ack_clr;
   wire [`MIRL_NUM_SRC-1:0] src_req;
   wire [`MIRL_NUM_SRC-1:0] src_en;
   wire [`MIRL_NUM_SRC-1:0] src_prio;
   wire                     win_valid;
   wire [3:0]               win_idx;
   wire                     win_prio;
   wire                     access;
   wire                     wr_fire;
   wire [7:0]               wd;
   wire [7:0]               en_p;
   wire [7:0]               en_s;
   wire [7:0]               pr_p;
   wire [7:0]               pr_s;

   // -------------------------------------------------------------------------
   // Pin inputs
   // -------------------------------------------------------------------------
   mirl_sync3 u_sync (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .pin_in  ({counter_two_external_pin, external_request_one_n,
                 external_request_zero_n}),
      .pin_lvl (pin_lvl)
   );

   // Converter-done is a level held until serviced, merged onto input one.
   assign ext_act  = {~pin_lvl[1] | adc_done, ~pin_lvl[0]};
   assign cap_fall = pin_prev_reg & ~pin_lvl[2];
   assign taken    = core_ack & core_request;

   genvar g;
   generate
      for (g = 0; g < `MIRL_NUM_SRC; g = g + 1) begin : g_ack
         assign ack_clr[g] = taken & (core_vector == g);
      end
   endgenerate

   // -------------------------------------------------------------------------
   // APB slave
   // -------------------------------------------------------------------------
   assign access  = psel & penable;
   assign wr_fire = access & pready & pwrite;
   assign wd      = pwdata[7:0];

   always @* begin
      hit     = 1'b1;
      rd_next = 32'h0000_0000;
      case (paddr)
         `MIRL_OFF_TIMER_CTRL: begin
            rd_next[`MIRL_TC_EDGE0] = edge_select_reg[0];
            rd_next[`MIRL_TC_FLAG0] = ext_flag_reg[0];
            rd_next[`MIRL_TC_EDGE1] = edge_select_reg[1];
            rd_next[`MIRL_TC_FLAG1] = ext_flag_reg[1];
            rd_next[`MIRL_TC_OVF0]  = counter_zero_overflow_flag_reg;
            rd_next[`MIRL_TC_OVF1]  = counter_one_overflow_flag_reg;
         end
         `MIRL_OFF_CNT2_CTRL: begin
            rd_next[`MIRL_C2_OVF]  = counter_two_overflow_flag_reg;
            rd_next[`MIRL_C2_CAP]  = counter_two_capture_flag_reg;
            rd_next[`MIRL_C2_EXEN] = counter_two_external_enable_reg;
         end
         `MIRL_OFF_EN_PRI:    rd_next[7:0] = enable_select_primary_reg;
         `MIRL_OFF_EN_SEC:    rd_next[7:0] = enable_select_secondary_reg;
         `MIRL_OFF_PRIO_PRI:  rd_next[7:0] = priority_select_primary_reg;
         `MIRL_OFF_PRIO_SEC:  rd_next[7:0] = priority_select_secondary_reg;
         `MIRL_OFF_CORE_STAT: rd_next[7:0] = {1'b0, hi_busy_reg, lo_busy_reg,
                                              core_request, core_vector};
         `MIRL_OFF_EVT_STAT:  rd_next[`MIRL_NUM_EVT-1:0] = evt_stat_reg;
         `MIRL_OFF_EVT_CLR:   rd_next = 32'h0000_0000;
         `MIRL_OFF_EVT_EN:    rd_next[`MIRL_NUM_EVT-1:0] = evt_en_reg;
         default:             hit = 1'b0;
      endcase
   end

   // The answer comes one cycle into the access phase; writes land with it.
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= access & ~pready;
         pslverr <= access & ~pready & ~hit;
         if (access && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_next;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Request flags
   // -------------------------------------------------------------------------
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_ext
         always @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               ext_flag_reg[g]     <= 1'b0;
               ext_act_prev_reg[g] <= 1'b0;
            end else begin
               ext_act_prev_reg[g] <= ext_act[g];
               if (!edge_select_reg[g]) begin
                  ext_flag_reg[g] <= ext_act[g];
               end else if (ext_act[g] && !ext_act_prev_reg[g]) begin
                  ext_flag_reg[g] <= 1'b1;
               end else if (ack_clr[g*4]) begin
                  ext_flag_reg[g] <= 1'b0;
               end else if (wr_fire && paddr == `MIRL_OFF_TIMER_CTRL) begin
                  ext_flag_reg[g] <= wd[`MIRL_TC_FLAG0 + 2*g];
               end
            end
         end
      end
   endgenerate

   // Hardware sets win over the auto-clear and over software writes.
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         edge_select_reg                 <= 2'b00;
         counter_zero_overflow_flag_reg  <= 1'b0;
         counter_one_overflow_flag_reg   <= 1'b0;
         counter_two_overflow_flag_reg   <= 1'b0;
         counter_two_capture_flag_reg    <= 1'b0;
         counter_two_external_enable_reg <= 1'b0;
         pin_prev_reg                    <= 1'b1;
      end else begin
         pin_prev_reg <= pin_lvl[2];
         if (wr_fire && paddr == `MIRL_OFF_TIMER_CTRL) begin
            edge_select_reg <= {wd[`MIRL_TC_EDGE1], wd[`MIRL_TC_EDGE0]};
         end
         if (t0_overflow && t0_mode != `MIRL_T0_SPLIT) begin
            counter_zero_overflow_flag_reg <= 1'b1;
         end else if (ack_clr[`MIRL_SRC_T0]) begin
            counter_zero_overflow_flag_reg <= 1'b0;
         end else if (wr_fire && paddr == `MIRL_OFF_TIMER_CTRL) begin
            counter_zero_overflow_flag_reg <= wd[`MIRL_TC_OVF0];
         end
         if (t1_overflow) begin
            counter_one_overflow_flag_reg <= 1'b1;
         end else if (ack_clr[`MIRL_SRC_T1]) begin
            counter_one_overflow_flag_reg <= 1'b0;
         end else if (wr_fire && paddr == `MIRL_OFF_TIMER_CTRL) begin
            counter_one_overflow_flag_reg <= wd[`MIRL_TC_OVF1];
         end
         if (t2_overflow) begin
            counter_two_overflow_flag_reg <= 1'b1;
         end else if (wr_fire && paddr == `MIRL_OFF_CNT2_CTRL) begin
            counter_two_overflow_flag_reg <= wd[`MIRL_C2_OVF];
         end
         if (cap_fall && counter_two_external_enable_reg) begin
            counter_two_capture_flag_reg <= 1'b1;
         end else if (wr_fire && paddr == `MIRL_OFF_CNT2_CTRL) begin
            counter_two_capture_flag_reg <= wd[`MIRL_C2_CAP];
         end
         if (wr_fire && paddr == `MIRL_OFF_CNT2_CTRL) begin
            counter_two_external_enable_reg <= wd[`MIRL_C2_EXEN];
         end
      end
   end

   // -------------------------------------------------------------------------
   // Enables, priorities and arbitration
   // -------------------------------------------------------------------------
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         enable_select_primary_reg     <= `MIRL_RST8;
         enable_select_secondary_reg   <= `MIRL_RST8;
         priority_select_primary_reg   <= `MIRL_RST8;
         priority_select_secondary_reg <= `MIRL_RST8;
      end else if (wr_fire) begin
         if (paddr == `MIRL_OFF_EN_PRI)   enable_select_primary_reg     <= wd;
         if (paddr == `MIRL_OFF_EN_SEC)   enable_select_secondary_reg   <= wd;
         if (paddr == `MIRL_OFF_PRIO_PRI) priority_select_primary_reg   <= wd;
         if (paddr == `MIRL_OFF_PRIO_SEC) priority_select_secondary_reg <= wd;
      end
   end

   assign en_p = enable_select_primary_reg;
   assign en_s = enable_select_secondary_reg;
   assign pr_p = priority_select_primary_reg;
   assign pr_s = priority_select_secondary_reg;

   // Index order is the polling order.
   assign src_req = {counter_two_overflow_flag_reg | counter_two_capture_flag_reg,
                     usart1_req, usb_req, counter_one_overflow_flag_reg, ddc_req,
                     ext_flag_reg[1], i2c_req, counter_zero_overflow_flag_reg,
                     usart2_req, ext_flag_reg[0]};
   assign src_en  = {`MIRL_NUM_SRC{en_p[`MIRL_EP_GATE]}} &
                    {en_p[`MIRL_EP_T2], en_p[`MIRL_EP_S1], en_s[`MIRL_ES_USB],
                     en_p[`MIRL_EP_T1], en_s[`MIRL_ES_DDC], en_p[`MIRL_EP_X1],
                     en_s[`MIRL_ES_I2C], en_p[`MIRL_EP_T0], en_s[`MIRL_ES_S2],
                     en_p[`MIRL_EP_X0]};
   assign src_prio = {pr_p[`MIRL_EP_T2], pr_p[`MIRL_EP_S1], pr_s[`MIRL_ES_USB],
                      pr_p[`MIRL_EP_T1], pr_s[`MIRL_ES_DDC], pr_p[`MIRL_EP_X1],
                      pr_s[`MIRL_ES_I2C], pr_p[`MIRL_EP_T0], pr_s[`MIRL_ES_S2],
                      pr_p[`MIRL_EP_X0]};

   mirl_arb u_arb (
      .req       (src_req & src_en),
      .prio      (src_prio),
      .lo_busy   (lo_busy_reg),
      .hi_busy   (hi_busy_reg),
      .win_valid (win_valid),
      .win_idx   (win_idx),
      .win_prio  (win_prio)
   );

   // -------------------------------------------------------------------------
   // Core handshake and in-service levels
   // -------------------------------------------------------------------------
   // The request drops for one cycle after a take so cleared flags settle.
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         core_request  <= 1'b0;
         core_vector   <= `MIRL_RST_VEC;
         core_prio_reg <= 1'b0;
         lo_busy_reg   <= 1'b0;
         hi_busy_reg   <= 1'b0;
      end else begin
         if (taken) begin
            core_request <= 1'b0;
            if (core_prio_reg) begin
               hi_busy_reg <= 1'b1;
            end else begin
               lo_busy_reg <= 1'b1;
            end
         end else begin
            if (core_return) begin
               if (hi_busy_reg) begin
                  hi_busy_reg <= 1'b0;
               end else begin
                  lo_busy_reg <= 1'b0;
               end
            end
            core_request  <= win_valid & ~core_return;
            core_vector   <= win_idx;
            core_prio_reg <= win_prio;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Event status and interrupt output
   // -------------------------------------------------------------------------
   always @* begin
      evt_stat_next = evt_stat_reg;
      if (wr_fire && paddr == `MIRL_OFF_EVT_CLR) begin
         evt_stat_next = evt_stat_reg & ~pwdata[`MIRL_NUM_EVT-1:0];
      end
      if (taken) begin
         evt_stat_next[`MIRL_EVT_TAKEN] = 1'b1;
      end
      if (core_return && !taken) begin
         evt_stat_next[`MIRL_EVT_DONE] = 1'b1;
      end
      if (taken && core_prio_reg && lo_busy_reg) begin
         evt_stat_next[`MIRL_EVT_PREEMPT] = 1'b1;
      end
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         evt_stat_reg <= `MIRL_RST_EVT;
         evt_en_reg   <= `MIRL_RST_EVT;
         irq          <= 1'b0;
      end else begin
         evt_stat_reg <= evt_stat_next;
         if (wr_fire && paddr == `MIRL_OFF_EVT_EN) begin
            evt_en_reg <= pwdata[`MIRL_NUM_EVT-1:0];
         end
         irq <= |(evt_stat_next & evt_en_reg);
      end
   end
endmodule
`default_nettype wire

// ===== dv/mirl_checker.sv
// Port-level assertions for the interrupt request logic.
`timescale 1ns/100ps
`default_nettype none
module mirl_checker (
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        t2_overflow,
   input wire logic        core_ack,
   input wire logic        core_request,
   input wire logic [3:0]  core_vector,
   input wire logic        irq
);
   logic       gate_q;
   logic [2:0] en_q;
   logic       t2_q;
   logic       wr_done;
   assign wr_done = psel && penable && pready && pwrite;
   // Shadow copies of the gate and event enables from completed writes, and of the timer 2 flag from overflow and writes.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         {gate_q, en_q, t2_q} <= 5'h00;
      end else begin
         if (wr_done && paddr == 8'h08) gate_q <= pwdata[7];
         if (wr_done && paddr == 8'h24) en_q <= pwdata[2:0];
         if (t2_overflow) t2_q <= 1'b1;
         else if (wr_done && paddr == 8'h04) t2_q <= pwdata[7];
      end
   end
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   a_apb_answer: assert property ($rose(psel && penable) |=> pready ##1 !pready)
      else $error("access not answered in second cycle");
   a_unmapped_err: assert property (psel && pready && paddr > 8'h24 |-> pslverr)
      else $error("unmapped access without error");
   a_ack_drops_req: assert property (core_ack && core_request |=> !core_request)
      else $error("request still offered after acknowledge");
   a_vector_range: assert property (core_request |-> core_vector <= 4'h9)
      else $error("vector outside the ten sources");
   a_gate_blocks: assert property (!gate_q && !$past(gate_q) |-> !core_request)
      else $error("request with global gate cleared");
   a_taken_irq: assert property (core_ack && core_request && en_q[0] |-> ##[1:3] irq)
      else $error("taken event raised no interrupt");
   a_irq_masked: assert property (en_q == 3'h0 && $past(en_q) == 3'h0 |-> !irq)
      else $error("interrupt with all events masked");
   a_t2_sticky: assert property (psel && pready && !pwrite && paddr == 8'h04
      |-> prdata[7] == $past(t2_q)) else $error("timer 2 overflow flag read back wrong");
endmodule
bind mirl_top mirl_checker mirl_checker_inst (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .t2_overflow(t2_overflow), .core_ack(core_ack),
   .core_request(core_request), .core_vector(core_vector), .irq(irq));
`default_nettype wire

// ===== dv/mirl_core_model.sv
// Processor core model: takes offered vectors and runs fixed-length service routines.
`timescale 1ns/100ps
`default_nettype none
module mirl_core_model (
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       core_request,
   input  wire logic [1:0] ack_delay,
   output var  logic       core_ack,
   output var  logic       core_return
);
   logic [3:0] cnt_reg;
   logic       busy_reg;
   // One routine at a time; the acknowledge waits a varying number of cycles.
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         {cnt_reg, busy_reg, core_ack, core_return} <= 7'h00;
      end else begin
         core_ack <= !busy_reg && !core_ack && core_request && cnt_reg[1:0] >= ack_delay;
         core_return <= busy_reg && cnt_reg == 4'ha;
         cnt_reg <= (core_ack || core_return || (!busy_reg && !core_request)) ? 4'h0 : cnt_reg + 4'h1;
         busy_reg <= (busy_reg && cnt_reg != 4'ha) || core_ack;
      end
   end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Self-checking testbench of the interrupt request logic.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, irq, noise, e;
   logic        x0_n, x1_n, cap_pin, adc, t0o, t1o, t2o, ack, ret, req;
   logic [4:0]  per;
   logic [1:0]  t0_mode;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rnd, q;
   logic [3:0]  vec;
   logic [3:0]  vq[$];
   int          mismatches, check_count;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      rnd <= xs(rnd);
      if (noise) {per, x1_n, adc} <= rnd[6:0];
      if (ack && req) vq.push_back(vec);
   end
   mirl_top mirl_top_inst (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_request_zero_n(x0_n), .external_request_one_n(x1_n),
      .counter_two_external_pin(cap_pin), .adc_done(adc), .t0_overflow(t0o), .t0_mode(t0_mode),
      .t1_overflow(t1o), .t2_overflow(t2o), .usart2_req(per[0]), .i2c_req(per[1]),
      .ddc_req(per[2]), .usb_req(per[3]), .usart1_req(per[4]), .core_ack(ack),
      .core_return(ret), .core_request(req), .core_vector(vec), .irq(irq));
   mirl_core_model mirl_core_model_inst (.clk_sys(clk_sys), .rstn(rstn), .core_request(req),
      .ack_delay(rnd[9:8]), .core_ack(ack), .core_return(ret));
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic give_up;
      mismatches++;
      test_done();
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) give_up();
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk($sformatf("register %h", a), x, q & m);
   endtask
   task automatic take(input logic [3:0] v);
      int n;
      for (n = 0; n < 300 && vq.size() == 0; n++) @(posedge clk_sys);
      if (n >= 300) give_up();
      chk("vector", {28'h0, v}, {28'h0, vq.pop_front()});
   endtask
   task automatic pulse(input logic [2:0] m);
      @(posedge clk_sys);
      {t2o, t1o, t0o} <= m;
      @(posedge clk_sys);
      {t2o, t1o, t0o} <= 3'h0;
   endtask
   task automatic fin(input string nm);
      repeat (40) @(posedge clk_sys);
      vq.delete();
      $display("test %s done", nm);
   endtask
   initial begin
      {rstn, psel, penable, pwrite, noise, t0o, t1o, t2o} = 8'h00;
      {x0_n, x1_n, cap_pin, adc, per, t0_mode} = 11'h700;
      {paddr, pwdata, rnd} = {8'h00, 32'h0, 32'h01350ff7};
      {mismatches, check_count} = {32'h0, 32'h0};
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      for (logic [7:0] a = 8'h00; a <= 8'h24; a += 8'h04) rc(a, 32'hffffffff, 32'h0);
      apb(1'b0, 8'h28, 32'h0);
      chk("error", 32'h1, {31'h0, e});
      t0_mode <= 2'h3;
      pulse(3'b001);
      rc(8'h00, 32'h20, 32'h0);
      {t0_mode, noise} <= 3'h1;
      apb(1'b1, 8'h24, 32'h7);
      pulse(3'b111);
      rc(8'h00, 32'hf7, 32'ha0);
      apb(1'b1, 8'h08, 32'hab);
      take(4'h2);
      take(4'h6);
      take(4'h9);
      rc(8'h00, 32'ha0, 32'h0);
      rc(8'h04, 32'h80, 32'h80);
      apb(1'b1, 8'h04, 32'h0);
      fin("polling order");
      apb(1'b1, 8'h08, 32'h2b);
      apb(1'b1, 8'h10, 32'h20);
      pulse(3'b101);
      apb(1'b1, 8'h08, 32'hab);
      take(4'h9);
      rc(8'h18, 32'h70, 32'h40);
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h10, 32'h0);
      fin("priority");
      rc(8'h00, 32'h20, 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      x0_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      x0_n <= 1'b1;
      take(4'h0);
      fin("edge input");
      rc(8'h00, 32'h02, 32'h0);
      apb(1'b1, 8'h08, 32'h2b);
      apb(1'b1, 8'h00, 32'h0);
      x0_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rc(8'h00, 32'h02, 32'h02);
      rc(8'h00, 32'h02, 32'h02);
      apb(1'b1, 8'h08, 32'hab);
      take(4'h0);
      x0_n <= 1'b1;
      fin("level input");
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, 8'h08, 32'h2b);
         apb(1'b1, 8'h04, k ? 32'h8 : 32'h0);
         cap_pin <= 1'b0;
         repeat (6) @(posedge clk_sys);
         cap_pin <= 1'b1;
         rc(8'h04, 32'hff, k ? 32'h48 : 32'h0);
      end
      apb(1'b1, 8'h08, 32'hab);
      take(4'h9);
      apb(1'b1, 8'h04, 32'h0);
      fin("capture");
      @(negedge clk_sys);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, 8'h24, 32'h0);
      repeat (2) @(negedge clk_sys);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b1, 8'h20, 32'h7);
      rc(8'h1c, 32'hff, 32'h0);
      apb(1'b1, 8'h24, 32'h7);
      pulse(3'b010);
      take(4'h6);
      rc(8'h1c, 32'h01, 32'h01);
      fin("interrupt");
      test_done();
   end
endmodule
`default_nettype wire
